// File: bench/dvc_compare_asserts.sv
module dvc_compare_asserts (
    // Clock and reset.
    input wire logic               CLK,
    input wire logic               RESETN,
    // Register port.
    input wire logic [7:0]         ADDR,
    input wire logic [31:0]        WDATA,
    input wire logic               WR,
    input wire logic               RD,
    input wire logic [31:0]        RDATA,
    // Access.
    input wire logic               ACC_VALID,
    input wire dvc_pkg::dvc_kind_t ACC_KIND,
    input wire logic               ACC_NOOP,
    input wire logic               ACC_RESERVED,
    input wire logic               ACC_STRING,
    input wire logic [6:0]         ACC_STRING_BYTE_COUNT,
    // Events and status.
    input wire logic               EVT_ONE_READ,
    input wire logic               EVT_ONE_WRITE,
    input wire logic               EVT_TWO_READ,
    input wire logic               EVT_TWO_WRITE,
    input wire logic               EVT_VALUE,
    input wire logic               EVT_ASYNC,
    input wire logic [3:0]         DEBUG_STATUS
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // Event bits in status order.
    wire logic [3:0] evts = {EVT_TWO_WRITE, EVT_TWO_READ, EVT_ONE_WRITE, EVT_ONE_READ};
    // Access kinds that carry no storage address or act as no-ops.
    sequence dead_kind;
        ACC_VALID && ACC_KIND inside {dvc_pkg::KIND_DALLOC, dvc_pkg::KIND_DALLINV, dvc_pkg::KIND_DREAD,
                                      dvc_pkg::KIND_IALLINV, dvc_pkg::KIND_IREAD};
    endsequence
    // No event of either unit on the following edge.
    sequence quiet_next;
        ##1 evts == 4'h0;
    endsequence
    chk_dead_kinds: assert property (dead_kind |-> quiet_next) else $error("event on dead kind");
    chk_idle_quiet: assert property (!ACC_VALID |-> quiet_next) else $error("event without access");
    chk_touch_noop: assert property (ACC_VALID && ACC_KIND == dvc_pkg::KIND_TOUCH && ACC_NOOP |-> quiet_next)
        else $error("event on no-op touch");
    chk_cstore_unres: assert property (ACC_VALID && ACC_KIND == dvc_pkg::KIND_CSTORE && !ACC_RESERVED
        |-> quiet_next) else $error("event on unreserved conditional store");
    chk_string_zero: assert property (ACC_VALID && ACC_STRING && ACC_STRING_BYTE_COUNT == 7'h00 |-> quiet_next)
        else $error("event on empty string access");
    chk_read_kinds: assert property (ACC_VALID && ACC_KIND inside {dvc_pkg::KIND_LOAD, dvc_pkg::KIND_TOUCH,
        dvc_pkg::KIND_IINVAL} |=> !EVT_ONE_WRITE && !EVT_TWO_WRITE) else $error("write event on read kind");
    chk_write_kinds: assert property (ACC_VALID && ACC_KIND inside {dvc_pkg::KIND_ZERO, dvc_pkg::KIND_DINVAL,
        dvc_pkg::KIND_DSTORE, dvc_pkg::KIND_DFLUSH} |=> !EVT_ONE_READ && !EVT_TWO_READ)
        else $error("read event on write kind");
    chk_value_needs: assert property (EVT_VALUE |-> evts != 4'h0) else $error("value event alone");
    chk_status_set: assert property ((evts & ~DEBUG_STATUS) == 4'h0) else $error("status missed event");
    chk_status_clear: assert property ($fell(DEBUG_STATUS[0])
        |-> $past(WR) && $past(ADDR) == 8'h18 && $past(WDATA[0])) else $error("status dropped without clear");
    chk_async_copy: assert property (WR && ADDR == 8'h0C |-> ##2 EVT_ASYNC == $past(WDATA[12], 2))
        else $error("async select not followed");
    chk_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0000_0000) else $error("read data outside slot");
endmodule

// File: bench/dvc_lsu_model.sv
module dvc_lsu_model (
    // Clock.
    input wire logic           clk,
    // Access toward the block, flags are {noop, reserved, string, count}.
    output logic               acc_valid,
    output dvc_pkg::dvc_kind_t acc_kind,
    output logic [31:0]        acc_addr,
    output logic [2:0]         acc_size,
    output logic [31:0]        acc_data,
    output logic [9:0]         acc_flags
);
    timeunit 1ns;
    timeprecision 1ns;
    // Quiet lines at time zero.
    initial begin
        acc_valid = 1'b0;
        acc_kind = dvc_pkg::KIND_LOAD;
        acc_addr = 32'h0000_0000;
        acc_size = 3'h1;
        acc_data = 32'h0000_0000;
        acc_flags = 10'h000;
    end
    // One access per call; a multi-access instruction calls once per access.
    task automatic put(input logic v, input logic [3:0] k, input logic [31:0] a, d, input logic [2:0] s,
                       input logic [9:0] f);
        @(posedge clk);
        acc_valid <= v;
        acc_kind <= dvc_pkg::dvc_kind_t'(k);
        acc_addr <= a;
        acc_size <= s;
        acc_data <= d;
        acc_flags <= f;
    endtask
    // Released address and data lines show the inverse of their last value; kind, size and flags hold.
    task automatic idle();
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_addr <= ~acc_addr;
        acc_data <= ~acc_data;
    endtask
endmodule

// File: bench/test_data_addr_value_debug_compare.sv
module test_data_addr_value_debug_compare;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RESETN = 0, WR = 0, RD = 0, on = 0;
    logic [7:0] ADDR = 0;
    logic [31:0] WDATA = 0, RDATA, v1 = 0, v2 = 0, a1 = 0, a2 = 0, r, d, aaddr, adata;
    logic [3:0] c0 = 0, st = 0, ds;
    logic [12:0] c2 = 0;
    logic [4:0] exp = 0;
    logic [4:0] expq[$];
    logic [9:0] af;
    logic [2:0] asz;
    logic av, e1r, e1w, e2r, e2w, ev, ea;
    dvc_pkg::dvc_kind_t akind;
    int mismatches = 0, n_compared = 0;
    integer seed = 9;
    dvc_lsu_model lsu (.clk(CLK), .acc_valid(av), .acc_kind(akind), .acc_addr(aaddr), .acc_size(asz),
                       .acc_data(adata), .acc_flags(af));
    dvc_compare DUT (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .ACC_VALID(av), .ACC_KIND(akind), .ACC_ADDR(aaddr), .ACC_SIZE(asz), .ACC_DATA(adata), .ACC_NOOP(af[9]),
        .ACC_RESERVED(af[8]), .ACC_STRING(af[7]), .ACC_STRING_BYTE_COUNT(af[6:0]), .EVT_ONE_READ(e1r),
        .EVT_ONE_WRITE(e1w), .EVT_TWO_READ(e2r), .EVT_TWO_WRITE(e2w), .EVT_VALUE(ev), .EVT_ASYNC(ea),
        .DEBUG_STATUS(ds));
    // Clock of 100 ns.
    initial forever #50 CLK = ~CLK;
    task automatic check(input string n, input logic [31:0] s, w);
        n_compared++;
        if (s !== w) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, w, s);
        end
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= w;
        @(posedge CLK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] w);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1 check("rdata", RDATA, w);
    endtask
    // Expected {value, two write, two read, one write, one read} for the access now presented.
    function automatic logic [4:0] model();
        int k, ok, rw, ww, vk, be, md, mm, nm, vm, hit;
        logic [31:0] v, a;
        logic [4:0] e;
        e = 5'h00;
        k = akind;
        ok = av && !(af[7] && af[6:0] == 7'h00);
        rw = k == 0 || k == 8 || (k == 6 && !af[9]);
        ww = (k >= 1 && k <= 5) || (k == 13 && af[8]);
        vk = k <= 2 || k == 13;
        for (int u = 0; u < 2; u++) begin
            v = u ? v2 : v1;
            a = u ? a2 : a1;
            be = (c2 >> 4 * u) & 15;
            md = (c2 >> (8 + 2 * u)) & 3;
            mm = 0;
            for (int i = 0; i < 4; i++) begin
                if (i >= aaddr[1:0] && i < aaddr[1:0] + asz && adata[31 - 8 * i -: 8] == v[31 - 8 * i -: 8]) begin
                    mm |= 1 << i;
                end
            end
            nm = be & ~mm;
            vm = md == 1 ? nm == 0 : md == 2 ? (be & mm) != 0 : md == 3 ?
                 ((be & 3) != 0 && (nm & 3) == 0) || ((be & 12) != 0 && (nm & 12) == 0) : 0;
            hit = ok && aaddr[31:2] == a[31:2] && (be == 0 || (vk && vm));
            e[2 * u] = hit && rw && c0[2 * u];
            e[2 * u + 1] = hit && ww && c0[2 * u + 1];
            if (be != 0 && e[2 * u +: 2] != 0) begin
                e[4] = 1'b1;
            end
        end
        return e;
    endfunction
    // Compares the events of the last taken access, then predicts the next one.
    // Predictions wait one cycle in a queue, the latency of the registered events.
    always @(negedge CLK) begin
        exp = (expq.size() != 0) ? expq.pop_front() : 5'h00;
        if (on) begin
            check("events", 32'({ev, e2w, e2r, e1w, e1r}), 32'(exp));
            st = st | exp[3:0];
            check("status", 32'(ds), 32'(st));
        end
        expq.push_back(on ? model() : 5'h00);
    end
    // New random compare setup, readback, status clear.
    task automatic cfg();
        v1 = $random(seed);
        v2 = $random(seed);
        a1 = $random(seed);
        a2 = seed[0] ? a1 : $random(seed);
        wr(8'h00, v1);
        wr(8'h04, v2);
        wr(8'h10, a1);
        wr(8'h14, a2);
        r = $random(seed);
        c0 = r[3:0];
        wr(8'h08, r);
        r = $random(seed);
        r[3:0] = r[20] ? 4'h0 : r[3:0];
        c2 = r[12:0];
        wr(8'h0C, r);
        rd(8'h08, 32'(c0));
        rd(8'h0C, 32'(c2));
        rd(8'h04, v2);
        rd(8'h18, 32'(st));
        wr(8'h18, 32'h0000_000F);
        st = 4'h0;
        check("async", 32'(ea), 32'(c2[12]));
    endtask
    // Reset, reset values, then random accesses in bursts.
    initial begin
        repeat (20) @(posedge CLK);
        RESETN <= 1'b1;
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0000_0000);
        on = 1'b1;
        for (int b = 0; b < 60; b++) begin
            cfg();
            for (int i = 0; i < 25; i++) begin
                r = $random(seed);
                d = r[10] ? v1 : v2;
                for (int j = 0; j < 4; j++) if (r[25 + j] && r[29]) d[8 * j +: 8] = ~d[8 * j +: 8];
                lsu.put(r[31:30] != 2'h0, 4'(r[3:0] % 14), (r[4] ? a1 : a2) ^ (r[7:5] == 3'h0 ? 32'h0000_0004 :
                        32'h0000_0000) ^ 32'(r[9:8]), d, 3'(r[12:11]) + 3'h1,
                        {r[13], r[14], r[15], r[16] ? 7'h00 : r[23:17]});
                if (r[24]) lsu.idle();
            end
            lsu.idle();
            repeat (2) @(posedge CLK);
        end
        finish_test();
    end
    // Bound on the whole run.
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        finish_test();
    end
endmodule
bind dvc_compare dvc_compare_asserts u_chk (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .ACC_VALID(ACC_VALID), .ACC_KIND(ACC_KIND), .ACC_NOOP(ACC_NOOP),
    .ACC_RESERVED(ACC_RESERVED), .ACC_STRING(ACC_STRING), .ACC_STRING_BYTE_COUNT(ACC_STRING_BYTE_COUNT),
    .EVT_ONE_READ(EVT_ONE_READ), .EVT_ONE_WRITE(EVT_ONE_WRITE), .EVT_TWO_READ(EVT_TWO_READ),
    .EVT_TWO_WRITE(EVT_TWO_WRITE), .EVT_VALUE(EVT_VALUE), .EVT_ASYNC(EVT_ASYNC), .DEBUG_STATUS(DEBUG_STATUS));

// File: common/dvc_consts.svh
`ifndef DVC_CONSTS_SVH
`define DVC_CONSTS_SVH

// Register word offsets on the plain register port.
`define DVC_OFS_VALUE_ONE    8'h00
`define DVC_OFS_VALUE_TWO    8'h04
`define DVC_OFS_CONTROL_ZERO 8'h08
`define DVC_OFS_CONTROL_TWO  8'h0C
`define DVC_OFS_ADDR_ONE     8'h10
`define DVC_OFS_ADDR_TWO     8'h14
`define DVC_OFS_STATUS       8'h18

// Control zero fields: address-compare enables.
`define DVC_C0_ONE_READ  0
`define DVC_C0_ONE_WRITE 1
`define DVC_C0_TWO_READ  2
`define DVC_C0_TWO_WRITE 3
`define DVC_C0_WIDTH     4

// Control two fields: byte enables, modes, async select.
`define DVC_C2_BE_ONE_LSB   0
`define DVC_C2_BE_TWO_LSB   4
`define DVC_C2_MODE_ONE_LSB 8
`define DVC_C2_MODE_TWO_LSB 10
`define DVC_C2_ASYNC        12
`define DVC_C2_WIDTH        13

// Status fields.
`define DVC_ST_ONE_READ  0
`define DVC_ST_ONE_WRITE 1
`define DVC_ST_TWO_READ  2
`define DVC_ST_TWO_WRITE 3
`define DVC_ST_WIDTH     4

// Reset values.
`define DVC_RST_WORD    32'h0000_0000
`define DVC_RST_C0      4'h0
`define DVC_RST_C2      13'h0000
`define DVC_RST_STATUS  4'h0

`endif

// File: common/dvc_pkg.sv
package dvc_pkg;

    // Kind of storage-accessing instruction behind one access.
    typedef enum logic [3:0] {
        KIND_LOAD    = 4'h0,
        KIND_STORE   = 4'h1,
        KIND_ZERO    = 4'h2,
        KIND_DINVAL  = 4'h3,
        KIND_DSTORE  = 4'h4,
        KIND_DFLUSH  = 4'h5,
        KIND_TOUCH   = 4'h6,
        KIND_DALLOC  = 4'h7,
        KIND_IINVAL  = 4'h8,
        KIND_DALLINV = 4'h9,
        KIND_DREAD   = 4'hA,
        KIND_IALLINV = 4'hB,
        KIND_IREAD   = 4'hC,
        KIND_CSTORE  = 4'hD
    } dvc_kind_t;

    // Value comparison mode.
    typedef enum logic [1:0] {
        MODE_NONE  = 2'h0,
        MODE_AND   = 2'h1,
        MODE_OR    = 2'h2,
        MODE_ANDOR = 2'h3
    } dvc_mode_t;

endpackage

// File: rtl/dvc_compare.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`include "dvc_consts.svh"
// Overview of operation
// - Each access of an instruction checked separately.
// - Line-zero and data invalidate count as writes.
// - Data store and flush count as writes.
// - Touches read; no event when no-op.
// - Data allocate never raises an event.
// - Instruction invalidate counts as a read.
// - Whole-cache and index instructions raise nothing.
// - Conditional store without reservation raises nothing.
// - String access with zero count raises nothing.
// - Value event needs address match plus data.
// - Two independent four-byte value registers.
// - Value event sets shared read/write status.
// - Zero byte enables disable value compare.
// - Enable bit n is lane n, lane 0 MSB.
// - Lane matches only if transferred and equal.
// - Only bytes in starting aligned word compared.
// - AND mode: all enabled lanes must match.
// - OR mode: any enabled lane matching suffices.
// - AND-OR mode: either lane pair ANDs true.
// - Value events use the same async selection.
// - Address and data of each access checked.
module dvc_compare (
    // Clock and reset.
    input  wire logic                  CLK,
    input  wire logic                  RESETN,
    // Register port.
    input  wire logic [7:0]            ADDR,
    input  wire logic [31:0]           WDATA,
    input  wire logic                  WR,
    input  wire logic                  RD,
    output logic      [31:0]           RDATA,
    // Access from the load/store pipeline.
    input  wire logic                  ACC_VALID,
    input  wire dvc_pkg::dvc_kind_t    ACC_KIND,
    input  wire logic [31:0]           ACC_ADDR,
    input  wire logic [2:0]            ACC_SIZE,
    input  wire logic [31:0]           ACC_DATA,
    input  wire logic                  ACC_NOOP,
    input  wire logic                  ACC_RESERVED,
    input  wire logic                  ACC_STRING,
    input  wire logic [6:0]            ACC_STRING_BYTE_COUNT,
    // Events toward the debug status logic.
    output logic                       EVT_ONE_READ,
    output logic                       EVT_ONE_WRITE,
    output logic                       EVT_TWO_READ,
    output logic                       EVT_TWO_WRITE,
    output logic                       EVT_VALUE,
    output logic                       EVT_ASYNC,
    output logic      [3:0]            DEBUG_STATUS
);

    // Software-visible state.
    logic [31:0]               value_one_reg;
    logic [31:0]               value_two_reg;
    logic [31:0]               addr_one_reg;
    logic [31:0]               addr_two_reg;
    logic [`DVC_C0_WIDTH-1:0]  control_zero_reg;
    logic [`DVC_C2_WIDTH-1:0]  control_two_reg;
    logic [`DVC_ST_WIDTH-1:0]  status_reg;
    logic [`DVC_ST_WIDTH-1:0]  status_next;

    // Decoded control fields.
    logic [3:0]                be_one;
    logic [3:0]                be_two;
    dvc_pkg::dvc_mode_t        mode_one;
    dvc_pkg::dvc_mode_t        mode_two;

    // Access classification.
    logic                      is_read;
    logic                      is_write;
    logic                      value_ok;
    logic [3:0]                lanes;
    logic [3:0]                match_one;
    logic [3:0]                match_two;
    logic                      value_hit_one;
    logic                      value_hit_two;
    logic                      addr_hit_one;
    logic                      addr_hit_two;
    logic [3:0]                events;

    assign be_one   = control_two_reg[`DVC_C2_BE_ONE_LSB +: 4];
    assign be_two   = control_two_reg[`DVC_C2_BE_TWO_LSB +: 4];
    assign mode_one = dvc_pkg::dvc_mode_t'(control_two_reg[`DVC_C2_MODE_ONE_LSB +: 2]);
    assign mode_two = dvc_pkg::dvc_mode_t'(control_two_reg[`DVC_C2_MODE_TWO_LSB +: 2]);

    // Lanes carried by an access, clipped to the word of the start byte.
    function automatic logic [3:0] lane_mask(input logic [1:0] ofs, input logic [2:0] size);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (i >= int'(ofs) && i < int'(ofs) + int'(size)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Per-lane equality; lane 0 is the most significant byte.
    function automatic logic [3:0] lane_match(input logic [31:0] data, input logic [31:0] val,
                                              input logic [3:0] acc);
        logic [3:0] m;
        m = 4'h0;
        for (int i = 0; i < 4; i++) begin
            m[i] = acc[i] && (data[31-8*i -: 8] == val[31-8*i -: 8]);
        end
        return m;
    endfunction

    // Mode evaluation over enabled lanes.
    function automatic logic mode_eval(input dvc_pkg::dvc_mode_t mode, input logic [3:0] be,
                                       input logic [3:0] m);
        logic pair_a;
        logic pair_b;
        logic r;
        pair_a = (be[1:0] != 2'b00) && ((m[1:0] & be[1:0]) == be[1:0]);
        pair_b = (be[3:2] != 2'b00) && ((m[3:2] & be[3:2]) == be[3:2]);
        case (mode)
            dvc_pkg::MODE_AND:   r = ((m & be) == be);
            dvc_pkg::MODE_OR:    r = ((m & be) != 4'h0);
            dvc_pkg::MODE_ANDOR: r = pair_a || pair_b;
            default:             r = 1'b0;
        endcase
        return r;
    endfunction

    // Sort the access into read, write or nothing by instruction kind.
    always_comb begin
        is_read  = 1'b0;
        is_write = 1'b0;
        value_ok = 1'b0;
        case (ACC_KIND)
            dvc_pkg::KIND_LOAD: begin
                is_read  = 1'b1;
                value_ok = 1'b1;
            end
            dvc_pkg::KIND_STORE: begin
                is_write = 1'b1;
                value_ok = 1'b1;
            end
            dvc_pkg::KIND_ZERO: begin
                is_write = 1'b1;
                value_ok = 1'b1;
            end
            dvc_pkg::KIND_DINVAL: begin
                is_write = 1'b1;
            end
            dvc_pkg::KIND_DSTORE,
            dvc_pkg::KIND_DFLUSH: begin
                is_write = 1'b1;
            end
            dvc_pkg::KIND_TOUCH: begin
                is_read = !ACC_NOOP;
            end
            dvc_pkg::KIND_IINVAL: begin
                is_read = 1'b1;
            end
            dvc_pkg::KIND_CSTORE: begin
                is_write = ACC_RESERVED;
                value_ok = ACC_RESERVED;
            end
            dvc_pkg::KIND_DALLOC: begin
                is_read = 1'b0;
            end
            default: begin
                is_read = 1'b0;
            end
        endcase
        if (!ACC_VALID || (ACC_STRING && ACC_STRING_BYTE_COUNT == 7'h00)) begin
            is_read  = 1'b0;
            is_write = 1'b0;
        end
    end

    // Each access is judged alone on its own address and data.
    always_comb begin
        lanes         = lane_mask(ACC_ADDR[1:0], ACC_SIZE);
        addr_hit_one  = (ACC_ADDR[31:2] == addr_one_reg[31:2]);
        addr_hit_two  = (ACC_ADDR[31:2] == addr_two_reg[31:2]);
        match_one     = lane_match(ACC_DATA, value_one_reg, lanes);
        match_two     = lane_match(ACC_DATA, value_two_reg, lanes);
        value_hit_one = value_ok && mode_eval(mode_one, be_one, match_one);
        value_hit_two = value_ok && mode_eval(mode_two, be_two, match_two);
        if (be_one != 4'h0) begin
            addr_hit_one = addr_hit_one && value_hit_one;
        end
        if (be_two != 4'h0) begin
            addr_hit_two = addr_hit_two && value_hit_two;
        end
        events[`DVC_ST_ONE_READ]  = addr_hit_one && is_read && control_zero_reg[`DVC_C0_ONE_READ];
        events[`DVC_ST_ONE_WRITE] = addr_hit_one && is_write && control_zero_reg[`DVC_C0_ONE_WRITE];
        events[`DVC_ST_TWO_READ]  = addr_hit_two && is_read && control_zero_reg[`DVC_C0_TWO_READ];
        events[`DVC_ST_TWO_WRITE] = addr_hit_two && is_write && control_zero_reg[`DVC_C0_TWO_WRITE];
    end

    // Event pulses, one cycle after the access, with the shared async select.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            EVT_ONE_READ  <= 1'b0;
            EVT_ONE_WRITE <= 1'b0;
            EVT_TWO_READ  <= 1'b0;
            EVT_TWO_WRITE <= 1'b0;
            EVT_VALUE     <= 1'b0;
            EVT_ASYNC     <= 1'b0;
        end else begin
            EVT_ONE_READ  <= events[`DVC_ST_ONE_READ];
            EVT_ONE_WRITE <= events[`DVC_ST_ONE_WRITE];
            EVT_TWO_READ  <= events[`DVC_ST_TWO_READ];
            EVT_TWO_WRITE <= events[`DVC_ST_TWO_WRITE];
            EVT_VALUE     <= ((events[1:0] != 2'b00) && be_one != 4'h0)
                          || ((events[3:2] != 2'b00) && be_two != 4'h0);
            EVT_ASYNC     <= control_two_reg[`DVC_C2_ASYNC];
        end
    end

    // Status: events set, a write of one clears, and a set beats a clear.
    always_comb begin
        status_next = status_reg;
        if (WR && ADDR == `DVC_OFS_STATUS) begin
            status_next = status_next & ~WDATA[`DVC_ST_WIDTH-1:0];
        end
        status_next = status_next | events;
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            status_reg <= `DVC_RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    assign DEBUG_STATUS = status_reg;

    // Register writes.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            value_one_reg    <= `DVC_RST_WORD;
            value_two_reg    <= `DVC_RST_WORD;
            addr_one_reg     <= `DVC_RST_WORD;
            addr_two_reg     <= `DVC_RST_WORD;
            control_zero_reg <= `DVC_RST_C0;
            control_two_reg  <= `DVC_RST_C2;
        end else if (WR) begin
            case (ADDR)
                `DVC_OFS_VALUE_ONE:    value_one_reg    <= WDATA;
                `DVC_OFS_VALUE_TWO:    value_two_reg    <= WDATA;
                `DVC_OFS_ADDR_ONE:     addr_one_reg     <= WDATA;
                `DVC_OFS_ADDR_TWO:     addr_two_reg     <= WDATA;
                `DVC_OFS_CONTROL_ZERO: control_zero_reg <= WDATA[`DVC_C0_WIDTH-1:0];
                `DVC_OFS_CONTROL_TWO:  control_two_reg  <= WDATA[`DVC_C2_WIDTH-1:0];
                default: begin
                end
            endcase
        end
    end

    // Read data, valid the cycle after the read strobe; unmapped reads zero.
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            RDATA <= 32'h0000_0000;
        end else if (RD) begin
            case (ADDR)
                `DVC_OFS_VALUE_ONE:    RDATA <= value_one_reg;
                `DVC_OFS_VALUE_TWO:    RDATA <= value_two_reg;
                `DVC_OFS_ADDR_ONE:     RDATA <= addr_one_reg;
                `DVC_OFS_ADDR_TWO:     RDATA <= addr_two_reg;
                `DVC_OFS_CONTROL_ZERO: RDATA <= {28'h000_0000, control_zero_reg};
                `DVC_OFS_CONTROL_TWO:  RDATA <= {19'h0_0000, control_two_reg};
                `DVC_OFS_STATUS:       RDATA <= {28'h000_0000, status_reg};
                default:               RDATA <= 32'h0000_0000;
            endcase
        end else begin
            RDATA <= 32'h0000_0000;
        end
    end

endmodule
